// File: rtl/clm_defs.svh
/*
 offsets, field positions and reset values of the loss-of-signal monitor.
 assumes byte-wide registers reached at their offsets.
*/
`ifndef CLM_DEFS_SVH
`define CLM_DEFS_SVH

`define CLM_OFS_NOM_MARGIN 4'h0
`define CLM_OFS_WIN_LO 4'h8
`define CLM_OFS_WIN_HI 4'h9
`define CLM_OFS_QUAL 4'ha
`define CLM_OFS_CTRL 4'hb
`define CLM_OFS_EVENT 4'hc
`define CLM_OFS_CNT 4'hd
`define CLM_OFS_STS 4'he

`define CLM_NOM_MSB 63
`define CLM_NOM_LSB 46
`define CLM_ACC_MSB 33
`define CLM_ACC_LSB 17
`define CLM_REJ_MSB 16
`define CLM_REJ_LSB 0

`define CLM_GAP_MSB 15
`define CLM_GAP_LSB 13
`define CLM_THR_MSB 12
`define CLM_THR_LSB 9
`define CLM_SEL_MSB 8
`define CLM_SEL_LSB 7
`define CLM_MASK_BIT 5
`define CLM_DIV_MSB 4
`define CLM_DIV_LSB 0

`define CLM_GOOD_MSB 7
`define CLM_GOOD_LSB 4
`define CLM_FAIL_MSB 3
`define CLM_FAIL_LSB 0
`define CLM_ENABLE_BIT 0
`define CLM_LMT_EVT_BIT 1
`define CLM_LOS_EVT_BIT 0
`define CLM_QUAL_STS_BIT 1
`define CLM_LOS_STS_BIT 0

`define CLM_RST_NOM_MARGIN 64'h0
`define CLM_RST_WIN 16'h0
`define CLM_RST_QUAL 8'h11
`define CLM_RST_CTRL 1'b0
`define CLM_RST_CNT 4'h0
`define CLM_RST_LOS_EVT 1'b1
`define CLM_RST_LMT_EVT 1'b0
`define CLM_CNT_MAX 4'hf
`define CLM_GAP_IGNORE_INST 4

`endif

// File: rtl/clm_pkg.sv
/*
 types and shared arithmetic of the loss-of-signal monitor.
 assumes nothing of its surroundings.
*/
package clm_pkg;
    typedef logic [21:0] clm_count_t;
    typedef logic [16:0] clm_margin_t;
    typedef enum logic [1:0] {CLM_OFF, CLM_LOSS, CLM_GOOD} clm_state_t;

    function automatic logic clm_in_band(input clm_count_t cnt, input clm_count_t ctr, input clm_margin_t m);
        clm_count_t diff;
        diff = (cnt >= ctr) ? (cnt - ctr) : (ctr - cnt);
        return diff <= {5'h0, m};
    endfunction : clm_in_band
endpackage : clm_pkg

// File: rtl/clm_window_timer.sv
/*
 window timer: divides the monitored clock and counts measuring ticks per window.
 assumes the monitored clock level and ticks are synchronous to i_clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clm_defs.svh"

module clm_window_timer (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_run,
    input wire logic i_ref_level,
    input wire logic i_meas_tick,
    input wire logic [4:0] i_div_ratio,
    output logic o_win_end,
    output clm_pkg::clm_count_t o_win_count
);
    logic ref_reg;
    logic started_reg;
    logic [4:0] div_reg;
    clm_pkg::clm_count_t cnt_reg;
    logic end_reg;

    wire ref_edge = i_ref_level & ~ref_reg;
    // ratio 0 or 1 is divide by one
    wire [4:0] last_div = (i_div_ratio <= 5'h1) ? 5'h0 : (i_div_ratio - 5'h1);
    wire boundary = i_run & ref_edge & (div_reg >= last_div);
    wire cnt_full = &cnt_reg;
    wire [21:0] cnt_inc = cnt_reg + {21'h0, i_meas_tick & ~cnt_full};

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            ref_reg <= 1'b0;
            started_reg <= 1'b0;
            div_reg <= 5'h0;
            cnt_reg <= '0;
            end_reg <= 1'b0;
            o_win_count <= '0;
        end else if (i_ce) begin
            ref_reg <= i_ref_level;
            end_reg <= boundary & started_reg;
            if (!i_run) begin
                started_reg <= 1'b0;
                div_reg <= 5'h0;
                cnt_reg <= '0;
            end else if (boundary) begin
                started_reg <= 1'b1;
                div_reg <= 5'h0;
                cnt_reg <= {21'h0, i_meas_tick};
                o_win_count <= cnt_reg;
            end else begin
                if (ref_edge) begin
                    div_reg <= div_reg + 5'h1;
                end
                cnt_reg <= cnt_inc;
            end
        end
    end

    assign o_win_end = end_reg;
endmodule : clm_window_timer
`default_nettype wire

// File: rtl/clm_monitor.sv
/*
 loss-of-signal monitor for one reference clock with byte-wide register port.
 assumes synchronous inputs, one-cycle strobes, and measuring ticks as enables.
*/
// Overview of operation
// - loss judged against nominal times one plus gap, plus or minus margin
// - instance four ignores gap setting and failure mask
// - counter-limit flag set while failure counter exceeds threshold
// - select field picks divided converter clock or one of three fractional dividers
// - mask bit clear lets loss status mark reference invalid
// - monitored clock divided by ratio; zero and one divide by one
// - enough consecutive accepted windows qualify clock and clear loss
// - enough rejected windows without qualifying disqualify clock and set loss
// - enable bit turns monitor on; disabled monitor holds loss asserted
// - counter-limit flag is write-one-clear and cannot clear while exceeded
// - loss flag is write-one-clear and cannot clear while loss persists
// - loss flag set on leaving reset; software clears after programming
// - accepted inside accept margin, rejected outside reject margin
// - failure counter counts loss assertions, saturates, written value presets it
// - nominal count per window; zero disables the monitor
`timescale 1ns/1ps
`default_nettype none
`include "clm_defs.svh"

module clm_monitor #(
    parameter int INSTANCE = 0
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_ref_clk,
    input wire logic i_time_to_digital_converter_tick,
    input wire logic i_fractional_divider_zero_clock_tick,
    input wire logic i_fractional_divider_one_clock_tick,
    input wire logic i_fractional_divider_two_clock_tick,
    output logic o_los_sts,
    output logic o_ref_qual,
    output logic o_ref_invalid
);
    logic [63:0] nom_margin_reg;
    logic [15:0] window_reg;
    logic [7:0] qual_reg;
    logic enable_reg;
    logic los_evt_reg;
    logic lmt_evt_reg;
    logic [3:0] fail_cnt_reg;
    logic [3:0] good_run_reg;
    logic [3:0] bad_run_reg;
    clm_pkg::clm_state_t state_reg;
    clm_pkg::clm_state_t state_next;
    logic los_prev_reg;
    logic [7:0] rdata_reg;

    logic win_end;
    clm_pkg::clm_count_t win_count;

    // register fields
    wire [17:0] nominal = nom_margin_reg[`CLM_NOM_MSB:`CLM_NOM_LSB];
    wire [16:0] acc_margin = nom_margin_reg[`CLM_ACC_MSB:`CLM_ACC_LSB];
    wire [16:0] rej_margin = nom_margin_reg[`CLM_REJ_MSB:`CLM_REJ_LSB];
    wire [2:0] gap_field = window_reg[`CLM_GAP_MSB:`CLM_GAP_LSB];
    wire [3:0] cnt_thresh = window_reg[`CLM_THR_MSB:`CLM_THR_LSB];
    wire [1:0] samp_sel = window_reg[`CLM_SEL_MSB:`CLM_SEL_LSB];
    wire mask_field = window_reg[`CLM_MASK_BIT];
    wire [4:0] div_ratio = window_reg[`CLM_DIV_MSB:`CLM_DIV_LSB];
    wire [3:0] good_times = qual_reg[`CLM_GOOD_MSB:`CLM_GOOD_LSB];
    wire [3:0] fail_times = qual_reg[`CLM_FAIL_MSB:`CLM_FAIL_LSB];

    // instance four ignores gap and mask
    wire is_fixed_inst = (INSTANCE == `CLM_GAP_IGNORE_INST);
    wire [2:0] gap_eff = is_fixed_inst ? 3'h0 : gap_field;
    wire mask_eff = is_fixed_inst ? 1'b0 : mask_field;

    // runs only when enabled with nonzero nominal
    wire run = enable_reg & (nominal != 18'h0);

    wire meas_tick = (samp_sel == 2'h0) ? i_time_to_digital_converter_tick :
                     (samp_sel == 2'h1) ? i_fractional_divider_zero_clock_tick :
                     (samp_sel == 2'h2) ? i_fractional_divider_one_clock_tick :
                                          i_fractional_divider_two_clock_tick;

    wire [21:0] scaled_nom = 22'(nominal) * 22'({1'b0, gap_eff} + 4'h1);
    wire accepted = clm_pkg::clm_in_band(win_count, scaled_nom, acc_margin);
    wire rejected = ~clm_pkg::clm_in_band(win_count, scaled_nom, rej_margin);

    // saturating four-bit step
    function automatic logic [3:0] clm_bump(input logic [3:0] v);
        return (v == `CLM_CNT_MAX) ? v : v + 4'h1;
    endfunction : clm_bump

    wire [3:0] good_inc = clm_bump(good_run_reg);
    wire [3:0] bad_inc = clm_bump(bad_run_reg);
    wire qualify = win_end & accepted & (good_inc >= good_times);
    wire disqualify = win_end & rejected & (bad_inc >= fail_times);

    wire los_now = (state_reg != clm_pkg::CLM_GOOD);
    wire los_rise = los_now & ~los_prev_reg;

    // register decode
    wire wr_nm = i_wr & (i_addr < `CLM_OFS_WIN_LO);
    wire wr_win_lo = i_wr & (i_addr == `CLM_OFS_WIN_LO);
    wire wr_win_hi = i_wr & (i_addr == `CLM_OFS_WIN_HI);
    wire wr_qual = i_wr & (i_addr == `CLM_OFS_QUAL);
    wire wr_ctrl = i_wr & (i_addr == `CLM_OFS_CTRL);
    wire wr_evt = i_wr & (i_addr == `CLM_OFS_EVENT);
    wire wr_cnt = i_wr & (i_addr == `CLM_OFS_CNT);

    // preset by write, increment on loss, saturate
    wire [3:0] cnt_base = wr_cnt ? i_wdata[3:0] : fail_cnt_reg;
    wire [3:0] fail_cnt_next = los_rise ? clm_bump(cnt_base) : cnt_base;

    wire lmt_cond = fail_cnt_reg > cnt_thresh;
    wire los_evt_next = los_now | (los_evt_reg & ~(wr_evt & i_wdata[`CLM_LOS_EVT_BIT]));
    wire lmt_evt_next = lmt_cond | (lmt_evt_reg & ~(wr_evt & i_wdata[`CLM_LMT_EVT_BIT]));

    wire [7:0] rd_mux = (i_addr < `CLM_OFS_WIN_LO) ? nom_margin_reg[{i_addr[2:0], 3'h0} +: 8] :
                        (i_addr == `CLM_OFS_WIN_LO) ? window_reg[7:0] & 8'hbf :
                        (i_addr == `CLM_OFS_WIN_HI) ? window_reg[15:8] :
                        (i_addr == `CLM_OFS_QUAL) ? qual_reg :
                        (i_addr == `CLM_OFS_CTRL) ? {7'h0, enable_reg} :
                        (i_addr == `CLM_OFS_EVENT) ? {6'h0, lmt_evt_reg, los_evt_reg} :
                        (i_addr == `CLM_OFS_CNT) ? {4'h0, fail_cnt_reg} :
                        (i_addr == `CLM_OFS_STS) ? {6'h0, ~los_now, los_now} : 8'h00;

    clm_window_timer u_timer (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_run(run),
        .i_ref_level(i_ref_clk),
        .i_meas_tick(meas_tick),
        .i_div_ratio(div_ratio),
        .o_win_end(win_end),
        .o_win_count(win_count)
    );

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            clm_pkg::CLM_OFF: begin
                if (run) begin
                    state_next = clm_pkg::CLM_LOSS;
                end
            end
            clm_pkg::CLM_LOSS: begin
                if (!run) begin
                    state_next = clm_pkg::CLM_OFF;
                end else if (qualify) begin
                    state_next = clm_pkg::CLM_GOOD;
                end
            end
            clm_pkg::CLM_GOOD: begin
                if (!run) begin
                    state_next = clm_pkg::CLM_OFF;
                end else if (disqualify) begin
                    state_next = clm_pkg::CLM_LOSS;
                end
            end
            default: begin
                state_next = clm_pkg::CLM_OFF;
            end
        endcase
    end

    // nominal and margin bytes
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            nom_margin_reg <= `CLM_RST_NOM_MARGIN;
        end else if (i_ce && wr_nm) begin
            nom_margin_reg[{i_addr[2:0], 3'h0} +: 8] <= i_wdata;
        end
    end

    // window configuration bytes
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            window_reg <= `CLM_RST_WIN;
        end else if (i_ce && wr_win_lo) begin
            window_reg[7:0] <= i_wdata;
        end else if (i_ce && wr_win_hi) begin
            window_reg[15:8] <= i_wdata;
        end
    end

    // qualification counts
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            qual_reg <= `CLM_RST_QUAL;
        end else if (i_ce && wr_qual) begin
            qual_reg <= i_wdata;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            enable_reg <= `CLM_RST_CTRL;
        end else if (i_ce && wr_ctrl) begin
            enable_reg <= i_wdata[`CLM_ENABLE_BIT];
        end
    end

    // state register
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= clm_pkg::CLM_OFF;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // loss level of the previous cycle
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            los_prev_reg <= 1'b1;
        end else if (i_ce) begin
            los_prev_reg <= los_now;
        end
    end

    // accepted window run
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            good_run_reg <= 4'h0;
        end else if (i_ce) begin
            if (!run || state_next != state_reg) begin
                good_run_reg <= 4'h0;
            end else if (win_end) begin
                good_run_reg <= accepted ? good_inc : 4'h0;
            end
        end
    end

    // rejected window run
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            bad_run_reg <= 4'h0;
        end else if (i_ce) begin
            if (!run || state_next != state_reg) begin
                bad_run_reg <= 4'h0;
            end else if (win_end && rejected) begin
                bad_run_reg <= bad_inc;
            end
        end
    end

    // loss event flag
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            // loss flag set out of reset
            los_evt_reg <= `CLM_RST_LOS_EVT;
        end else if (i_ce) begin
            los_evt_reg <= los_evt_next;
        end
    end

    // counter-limit event flag
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            lmt_evt_reg <= `CLM_RST_LMT_EVT;
        end else if (i_ce) begin
            lmt_evt_reg <= lmt_evt_next;
        end
    end

    // failure counter
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            fail_cnt_reg <= `CLM_RST_CNT;
        end else if (i_ce) begin
            fail_cnt_reg <= fail_cnt_next;
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rdata_reg <= 8'h00;
        end else if (i_ce) begin
            rdata_reg <= i_rd ? rd_mux : 8'h00;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_los_sts = los_now;
    assign o_ref_qual = ~los_now;
    assign o_ref_invalid = los_now & ~mask_eff;
endmodule : clm_monitor
`default_nettype wire

// File: verif/clm_chk_monitor.sv
/*
 concurrent checks on the loss-of-signal monitor ports.
 assumes one clock domain and a bind from the bench top.
*/
`timescale 1ns/1ps
`default_nettype none
module clm_chk (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic o_los_sts,
    input wire logic o_ref_qual,
    input wire logic o_ref_invalid
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    a_qual_inverse: assert property (o_ref_qual != o_los_sts)
        else $error("qualified status not inverse of loss");
    a_invalid_needs_loss: assert property (o_ref_invalid |-> o_los_sts)
        else $error("invalid without loss");
    a_reset_loss: assert property ($fell(i_reset) |-> o_los_sts && !o_ref_qual)
        else $error("loss not held after reset");
    a_disable_loss: assert property (i_ce && i_wr && i_addr == 4'hb && !i_wdata[0] |-> ##[1:2] o_los_sts)
        else $error("loss not raised on disable");
    a_loss_evt_read: assert property (i_ce && i_rd && i_addr == 4'hc && o_los_sts && $past(o_los_sts) |=> o_rdata[0])
        else $error("loss event clear while loss");
    a_sts_read: assert property (i_ce && i_rd && i_addr == 4'he |=> o_rdata == {6'h0, $past(o_ref_qual), $past(o_los_sts)})
        else $error("status read differs from outputs");
    a_cnt_reserved: assert property (i_ce && i_rd && i_addr == 4'hd |=> o_rdata[7:4] == 4'h0)
        else $error("counter upper bits not zero");
    a_evt_reserved: assert property (i_ce && i_rd && i_addr == 4'hc |=> o_rdata[7:2] == 6'h0)
        else $error("event upper bits not zero");
endmodule : clm_chk
`default_nettype wire

// File: verif/clm_ref_gen.sv
/*
 monitored reference clock and four measuring tick streams.
 assumes the bench sets the half period in system clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module clm_ref_gen (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [7:0] i_half,
    output logic o_ref,
    output logic [3:0] o_tick
);
    logic [7:0] half_cnt_reg;
    logic [3:0] tick_cnt_reg;
    assign o_tick = {tick_cnt_reg[1:0] == 2'h0, tick_cnt_reg % 4'h3 == 4'h0, !tick_cnt_reg[0], 1'b1};
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            half_cnt_reg <= 8'h0;
            tick_cnt_reg <= 4'h0;
            o_ref <= 1'b0;
        end else begin
            tick_cnt_reg <= (tick_cnt_reg == 4'hb) ? 4'h0 : tick_cnt_reg + 4'h1;
            if (half_cnt_reg + 8'h1 >= i_half) begin
                half_cnt_reg <= 8'h0;
                o_ref <= ~o_ref;
            end else begin
                half_cnt_reg <= half_cnt_reg + 8'h1;
            end
        end
    end
endmodule : clm_ref_gen
`default_nettype wire

// File: verif/clock_loss_of_signal_monitor_tb.sv
/*
 self-checking bench of the loss-of-signal monitor.
 assumes the reference generator and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
module clock_loss_of_signal_monitor_tb;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] half = 8'h8;
    logic [7:0] o_rdata;
    logic ref_clk;
    logic [3:0] tick;
    logic o_los_sts;
    logic o_ref_qual;
    logic o_ref_invalid;
    logic los4;
    logic inv4;
    logic ce = 1'b1;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    clm_monitor u_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ref_clk(ref_clk),
        .i_time_to_digital_converter_tick(tick[0]), .i_fractional_divider_zero_clock_tick(tick[1]),
        .i_fractional_divider_one_clock_tick(tick[2]), .i_fractional_divider_two_clock_tick(tick[3]),
        .o_los_sts(o_los_sts), .o_ref_qual(o_ref_qual), .o_ref_invalid(o_ref_invalid));
    clm_ref_gen u_ref (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_half(half), .o_ref(ref_clk), .o_tick(tick));
    clm_monitor #(.INSTANCE(4)) u_dut_four (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(), .i_ref_clk(ref_clk),
        .i_time_to_digital_converter_tick(tick[0]), .i_fractional_divider_zero_clock_tick(tick[1]),
        .i_fractional_divider_one_clock_tick(tick[2]), .i_fractional_divider_two_clock_tick(tick[3]),
        .o_los_sts(los4), .o_ref_qual(), .o_ref_invalid(inv4));
    initial begin
        forever #25 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    task wrap_up;
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr
    task rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        `CHK("rdata", e, o_rdata)
    endtask : rd_chk
    task wait_los(input logic e);
        int n;
        n = 0;
        while (n < 600 && !(e == 1'b0 && o_los_sts === 1'b0)) begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        #1;
    endtask : wait_los
    task cfg(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] hp, input logic e);
        wr(4'hb, 8'h0);
        repeat (2) @(posedge i_clk_sys);
        #1;
        `CHK("los_off", 1'b1, o_los_sts) // loss while disabled
        wr(4'h8, lo);
        wr(4'h9, hi);
        half <= hp;
        wr(4'hb, 8'h1);
        wait_los(e);
        `CHK("los", e, o_los_sts) // loss after windows
        `CHK("invalid", e & ~lo[5], o_ref_invalid) // masked invalid
        rd_chk(4'he, e ? 8'h01 : 8'h02); // status register
    endtask : cfg
    task t_reset;
        #1;
        `CHK("los_rst", 1'b1, o_los_sts) // loss after reset
        rd_chk(4'ha, 8'h11); // count defaults
        wr(4'ha, 8'h21);
        rd_chk(4'ha, 8'h21); // two windows to qualify
        rd_chk(4'hc, 8'h01); // loss event set
        rd_chk(4'hd, 8'h00); // counter clear
        rd_chk(4'hb, 8'h00); // monitor off
        rd_chk(4'hf, 8'h00);
        wr(4'hc, 8'h01);
        rd_chk(4'hc, 8'h01); // clear refused
    endtask : t_reset
    task t_cfg;
        cfg(8'h00, 8'h01, 8'd8, 1'b0); // plain qualify
        cfg(8'h00, 8'h00, 8'd8, 1'b0); // ratio zero
        cfg(8'h00, 8'h81, 8'd16, 1'b0); // select one
        cfg(8'h01, 8'h01, 8'd24, 1'b0); // select two
        cfg(8'h01, 8'h81, 8'd32, 1'b0); // select three
        cfg(8'h20, 8'h01, 8'd16, 1'b0); // gap scaling
        cfg(8'h20, 8'h02, 8'd8, 1'b0); // ratio two
        cfg(8'h20, 8'h01, 8'd8, 1'b1); // gap rejects short
        cfg(8'h00, 8'h21, 8'd40, 1'b1); // slow rejected
    endtask : t_cfg
    task t_fail;
        cfg(8'h00, 8'h01, 8'd8, 1'b0);
        wr(4'hd, 8'h00);
        wr(4'hc, 8'h03);
        rd_chk(4'hc, 8'h00); // clear accepted
        half <= 8'd40;
        wait_los(1'b1);
        `CHK("los_slow", 1'b1, o_los_sts) // disqualify
        rd_chk(4'hd, 8'h01); // one failure
        rd_chk(4'hc, 8'h03); // above threshold
        wr(4'hc, 8'h02);
        rd_chk(4'hc, 8'h03); // clear refused
        wr(4'hd, 8'h00);
        wr(4'hc, 8'h02);
        rd_chk(4'hc, 8'h01); // clear after counter
        wr(4'hb, 8'h00);
        wr(4'hd, 8'h05);
        wr(4'h9, 8'h0a);
        wr(4'hc, 8'h02);
        rd_chk(4'hc, 8'h01); // equal not exceeded
        rd_chk(4'hd, 8'h05); // preset value
    endtask : t_fail
    task t_inst4;
        cfg(8'h20, 8'h21, 8'd8, 1'b1); // gap rejects short
        `CHK("los4_gap", 1'b0, los4) // gap ignored
        @(posedge i_clk_sys);
        half <= 8'd40;
        wait_los(1'b1);
        `CHK("inv4_mask", 1'b1, inv4) // mask ignored
        `CHK("inv_mask", 1'b0, o_ref_invalid) // mask hides loss
    endtask : t_inst4
    task t_freeze;
        @(posedge i_clk_sys);
        ce <= 1'b0;
        wr(4'hd, 8'h09);
        ce <= 1'b1;
        rd_chk(4'hd, 8'h05); // frozen write dropped
    endtask : t_freeze
    initial begin
        repeat (6) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        t_reset();
        wr(4'h0, 8'h04);
        wr(4'h2, 8'h04);
        wr(4'h6, 8'h04);
        t_cfg();
        t_inst4();
        t_fail();
        t_freeze();
        wrap_up();
    end
endmodule : clock_loss_of_signal_monitor_tb
bind clm_monitor clm_chk u_chk (.i_clk_sys, .i_reset, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_los_sts, .o_ref_qual, .o_ref_invalid);
`default_nettype wire
